// File: src/bss_top.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - only command register or fb writes start drawing
// - mode selects op; fb or command start
// - 3D lines only via command writes
// - slope word: dy high, dx low
// - slope write loads signed initial error
// - slope write yields 4-bit segment length
// - negative error: add increment 1
// - nonnegative error: subtract increment 2
// - eight registers, each one octant
// - length is major magnitude modulo 16
// - continue write draws exactly 16 pixels
// - environment bit alters term generation
// - slope registers read zero after reset
// - engine state kept after segment ends
module bss_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Direct frame buffer write
	input wire logic fb_wr_valid,
	input wire logic [23:0] fb_wr_addr,
	output logic fb_wr_ready,
	// Pixel output
	output bss_pkg::bss_pix_t pix,
	output logic pix_valid,
	input wire logic pix_ready,
	// Engine status
	output logic busy
);

	// ************************************************
	// Registers and state
	// ************************************************
	typedef enum logic {ST_IDLE, ST_DRAW} bss_state_t;

	bss_state_t state_r;
	logic [31:0] slope_r [8];
	logic [1:0] mode_sel_r;
	logic env_r;
	logic [15:0] width_r;
	bss_pkg::bss_terms_t terms_r;
	bss_pkg::bss_terms_t new_terms;
	logic signed [15:0] err_r;
	logic signed [15:0] err_nxt;
	logic [23:0] addr_r;
	logic [23:0] addr_nxt;
	logic [3:0] len_r;
	logic [4:0] cnt_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic pix_valid_r;
	bss_pkg::bss_pix_t pix_r;

	// ************************************************
	// Address decode
	// ************************************************
	logic is_slope;
	logic is_mode;
	logic is_width;
	logic is_cont;
	logic is_seglen;
	logic is_err;
	logic is_addr;
	logic is_mapped;
	logic is_stall_cls;
	logic [2:0] oct_idx;

	always_comb begin
		is_slope = 1'b0;
		is_mode = 1'b0;
		is_width = 1'b0;
		is_cont = 1'b0;
		is_seglen = 1'b0;
		is_err = 1'b0;
		is_addr = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			is_mode = 1'b0;
		end else if (paddr < bss_pkg::OFS_MODE) begin
			is_slope = 1'b1;
		end else if (paddr == bss_pkg::OFS_MODE) begin
			is_mode = 1'b1;
		end else if (paddr == bss_pkg::OFS_WIDTH) begin
			is_width = 1'b1;
		end else if (paddr == bss_pkg::OFS_CONT) begin
			is_cont = 1'b1;
		end else if (paddr == bss_pkg::OFS_SEGLEN) begin
			is_seglen = 1'b1;
		end else if (paddr == bss_pkg::OFS_ERR) begin
			is_err = 1'b1;
		end else if (paddr == bss_pkg::OFS_ADDR) begin
			is_addr = 1'b1;
		end
	end

	assign is_mapped = is_slope | is_mode | is_width | is_cont | is_seglen | is_err | is_addr;
	assign oct_idx = paddr[bss_pkg::OCT_LSB +: 3];
	// Writes that touch the engine wait for the segment to end
	assign is_stall_cls = is_slope | is_cont | is_addr | is_width | is_mode;

	// ************************************************
	// Bus handshake
	// ************************************************
	logic wr_en;
	logic setup;
	logic slope_wr;
	logic cont_wr;
	logic line_mode;
	logic start_slope;
	logic start_cont;
	logic fb_start;
	logic step_go;
	logic last_step;

	assign busy = (state_r == ST_DRAW);
	assign pready = !(pwrite && is_stall_cls && busy);
	assign wr_en = psel && penable && pwrite && pready;
	assign setup = psel && !penable;
	assign slope_wr = wr_en && is_slope;
	assign cont_wr = wr_en && is_cont;
	assign line_mode = (mode_sel_r == bss_pkg::MODE_LINE) || (mode_sel_r == bss_pkg::MODE_LINE3D);
	assign start_slope = slope_wr && line_mode;
	assign start_cont = cont_wr && line_mode;
	// fb writes start 2D lines only
	assign fb_wr_ready = !busy && !(psel && pwrite && is_stall_cls);
	assign fb_start = fb_wr_valid && fb_wr_ready && (mode_sel_r == bss_pkg::MODE_LINE);
	assign step_go = busy && (!pix_valid_r || pix_ready);
	assign last_step = step_go && (cnt_r == 5'h01);

	// ************************************************
	// Term generation and stepping
	// ************************************************
	bss_terms u_terms (
		.dx(pwdata[15:0]),
		.dy(pwdata[31:16]),
		.octant(oct_idx),
		.width(width_r),
		.env_alt(env_r),
		.terms(new_terms)
	);

	bss_step u_step (
		.err(err_r),
		.addr(addr_r),
		.terms(terms_r),
		.err_nxt(err_nxt),
		.addr_nxt(addr_nxt)
	);

	// ************************************************
	// Software registers
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				slope_r[i] <= bss_pkg::RST_WORD;
			end
		end else if (slope_wr) begin
			slope_r[oct_idx] <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sel_r <= bss_pkg::MODE_SIMPLE;
			env_r <= 1'b0;
			width_r <= 16'h0000;
		end else if (wr_en && is_mode) begin
			mode_sel_r <= pwdata[1:0];
			env_r <= pwdata[bss_pkg::MODE_ENV_BIT];
		end else if (wr_en && is_width) begin
			width_r <= pwdata[15:0];
		end
	end

	// ************************************************
	// Bresenham engine
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			terms_r <= '0;
			len_r <= 4'h0;
		end else if (slope_wr) begin
			terms_r <= new_terms;
			len_r <= new_terms.len;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_r <= 16'sh0000;
			addr_r <= 24'h000000;
		end else if (slope_wr) begin
			err_r <= new_terms.err;
		end else if (wr_en && is_addr) begin
			addr_r <= pwdata[23:0];
		end else if (fb_start) begin
			addr_r <= fb_wr_addr;
		end else if (step_go) begin
			err_r <= err_nxt;
			addr_r <= addr_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cnt_r <= 5'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					// only command or fb writes start
					if (start_slope) begin
						state_r <= ST_DRAW;
						cnt_r <= (new_terms.len == 4'h0) ? bss_pkg::SEG_PIXELS
							: {1'b0, new_terms.len};
					end else if (start_cont || fb_start) begin
						state_r <= ST_DRAW;
						cnt_r <= bss_pkg::SEG_PIXELS;
					end
				end
				ST_DRAW: begin
					if (step_go) begin
						cnt_r <= cnt_r - 5'h01;
					end
					if (last_step) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************
	// Pixel output
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_valid_r <= 1'b0;
			pix_r <= '0;
		end else if (step_go) begin
			pix_valid_r <= 1'b1;
			pix_r.addr <= addr_r;
			pix_r.is3d <= (mode_sel_r == bss_pkg::MODE_LINE3D);
		end else if (pix_ready) begin
			pix_valid_r <= 1'b0;
		end
	end

	assign pix = pix_r;
	assign pix_valid = pix_valid_r;

	// ************************************************
	// Read data
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= bss_pkg::RST_WORD;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			pslverr_r <= !is_mapped;
			prdata_r <= bss_pkg::RST_WORD;
			if (pwrite) begin
				prdata_r <= bss_pkg::RST_WORD;
			end else if (is_slope) begin
				prdata_r <= slope_r[oct_idx];
			end else if (is_mode) begin
				prdata_r[1:0] <= mode_sel_r;
				prdata_r[bss_pkg::MODE_ENV_BIT] <= env_r;
			end else if (is_width) begin
				prdata_r[15:0] <= width_r;
			end else if (is_seglen) begin
				prdata_r[3:0] <= len_r;
				prdata_r[bss_pkg::SEGLEN_CNT_LSB +: 5] <= cnt_r;
				prdata_r[bss_pkg::SEGLEN_BUSY_BIT] <= busy;
			end else if (is_err) begin
				prdata_r[15:0] <= err_r;
			end else if (is_addr) begin
				prdata_r[23:0] <= addr_r;
			end
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [5:0] px_h;
	logic [4:0] exp_h;
	logic [15:0] maj_h;

	assign maj_h = (pwdata[15:0] >= pwdata[31:16]) ? pwdata[15:0] : pwdata[31:16];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			px_h <= 6'h00;
			exp_h <= 5'h00;
		end else if (!busy && (start_slope || start_cont || fb_start)) begin
			px_h <= 6'h00;
			exp_h <= (start_slope && new_terms.len != 4'h0) ? {1'b0, new_terms.len}
				: bss_pkg::SEG_PIXELS;
		end else if (step_go) begin
			px_h <= px_h + 6'h01;
		end
	end

	sequence s_cont_req;
		!busy && start_cont;
	endsequence

	sequence s_full_seg;
		busy && (cnt_r == bss_pkg::SEG_PIXELS);
	endsequence

	chk_start_source: assert property (
		$rose(busy) |-> $past((wr_en && (is_slope || is_cont)) || (fb_wr_valid && fb_wr_ready)))
		else $error("drawing started without a command or fb write");

	chk_mode_gate: assert property (
		(!busy && slope_wr && mode_sel_r == bss_pkg::MODE_SIMPLE && !fb_wr_valid) |=> !busy)
		else $error("slope write drew in simple mode");

	chk_fb_no_3d: assert property (
		(!busy && fb_wr_valid && mode_sel_r == bss_pkg::MODE_LINE3D && !wr_en) |=> !busy)
		else $error("fb write started a 3D line");

	chk_slope_store: assert property (
		slope_wr |=> slope_r[$past(oct_idx)] == $past(pwdata))
		else $error("slope word not stored");

	chk_err_load: assert property (
		slope_wr |=> (err_r == $past(new_terms.err)) && (terms_r == $past(new_terms)))
		else $error("initial error not loaded");

	chk_len_mod16: assert property (
		slope_wr |=> len_r == $past(maj_h[3:0]))
		else $error("segment length not major modulo 16");

	chk_major_step: assert property (
		(step_go && err_r < 16'sh0000) |=>
			(err_r == $past(err_r) + $signed($past(terms_r.einc1)))
			&& (addr_r == $past(addr_r) + $past(terms_r.ainc1)))
		else $error("major step wrong");

	chk_diag_step: assert property (
		(step_go && err_r >= 16'sh0000) |=>
			(err_r == $past(err_r) - $signed($past(terms_r.einc2)))
			&& (addr_r == $past(addr_r) + $past(terms_r.ainc2)))
		else $error("diagonal step wrong");

	chk_octant_dir: assert property (
		(slope_wr && !oct_idx[bss_pkg::OCT_YMAJ] && oct_idx[bss_pkg::OCT_XNEG])
			|=> terms_r.ainc1 == 24'sh7FFFFF + 24'sh7FFFFF + 24'sh000001)
		else $error("x-major negative octant must step by minus one");

	chk_cont_sixteen: assert property (
		s_cont_req |=> s_full_seg)
		else $error("continue did not load 16 pixels");

	chk_seg_count: assert property (
		$fell(busy) |-> px_h == {1'b0, exp_h})
		else $error("segment pixel count mismatch");

	chk_hold_idle: assert property (
		(!busy && !wr_en && !fb_start) |=> $stable(err_r) && $stable(addr_r))
		else $error("engine state lost while idle");

endmodule : bss_top

// File: include/bss_pkg.sv
package bss_pkg;

	// ************************************************
	// Widths
	// ************************************************
	localparam int PADDR_W = 12;
	localparam int FB_AW = 24;
	localparam int MAG_W = 16;

	// ************************************************
	// Register byte offsets
	// ************************************************
	localparam logic [11:0] OFS_SLOPE0 = 12'h000;
	localparam logic [11:0] OFS_MODE = 12'h020;
	localparam logic [11:0] OFS_WIDTH = 12'h024;
	localparam logic [11:0] OFS_CONT = 12'h028;
	localparam logic [11:0] OFS_SEGLEN = 12'h02C;
	localparam logic [11:0] OFS_ERR = 12'h030;
	localparam logic [11:0] OFS_ADDR = 12'h034;

	// ************************************************
	// Field positions and codes
	// ************************************************
	localparam int SLOPE_DY_LSB = 16;
	localparam int OCT_LSB = 2;
	localparam int OCT_XNEG = 0;
	localparam int OCT_YNEG = 1;
	localparam int OCT_YMAJ = 2;
	localparam int MODE_ENV_BIT = 13;
	localparam int SEGLEN_CNT_LSB = 4;
	localparam int SEGLEN_BUSY_BIT = 31;
	localparam logic [1:0] MODE_SIMPLE = 2'h0;
	localparam logic [1:0] MODE_LINE = 2'h1;
	localparam logic [1:0] MODE_LINE3D = 2'h2;
	localparam logic [4:0] SEG_PIXELS = 5'h10;
	localparam logic [31:0] RST_WORD = 32'h00000000;

	// ************************************************
	// Carriers
	// ************************************************
	typedef struct packed {
		logic signed [15:0] err;
		logic [3:0] len;
		logic [15:0] einc1;
		logic [15:0] einc2;
		logic signed [23:0] ainc1;
		logic signed [23:0] ainc2;
	} bss_terms_t;

	typedef struct packed {
		logic [23:0] addr;
		logic is3d;
	} bss_pix_t;

endpackage : bss_pkg

// File: src/bss_terms.sv
`timescale 1ns/10ps
module bss_terms (
	// Slope magnitudes and octant
	input wire logic [15:0] dx,
	input wire logic [15:0] dy,
	input wire logic [2:0] octant,
	// Setup context
	input wire logic [15:0] width,
	input wire logic env_alt,
	// Derived terms
	output bss_pkg::bss_terms_t terms
);
	logic [15:0] major;
	logic [15:0] minor;
	logic [17:0] err_full;
	logic [16:0] diff2;
	logic signed [23:0] xs;
	logic signed [23:0] ys;

	assign major = (dx >= dy) ? dx : dy;
	assign minor = (dx >= dy) ? dy : dx;
	assign err_full = {1'b0, minor, 1'b0} - {2'h0, major} - {17'h00000, env_alt};
	assign diff2 = {major - minor, 1'b0};
	assign xs = octant[bss_pkg::OCT_XNEG] ? 24'hFFFFFF : 24'h000001;
	assign ys = octant[bss_pkg::OCT_YNEG] ? -$signed({8'h00, width}) : $signed({8'h00, width});

	always_comb begin
		terms.err = err_full[15:0];
		terms.len = major[3:0];
		terms.einc1 = {minor[14:0], 1'b0};
		terms.einc2 = diff2[15:0];
		terms.ainc1 = octant[bss_pkg::OCT_YMAJ] ? ys : xs;
		terms.ainc2 = xs + ys;
	end

endmodule : bss_terms

// File: src/bss_step.sv
`timescale 1ns/10ps
module bss_step (
	// Current engine state
	input wire logic signed [15:0] err,
	input wire logic [23:0] addr,
	input bss_pkg::bss_terms_t terms,
	// Next engine state
	output logic signed [15:0] err_nxt,
	output logic [23:0] addr_nxt
);
	always_comb begin
		if (err < 16'sh0000) begin
			err_nxt = err + $signed(terms.einc1);
			addr_nxt = addr + terms.ainc1;
		end else begin
			err_nxt = err - $signed(terms.einc2);
			addr_nxt = addr + terms.ainc2;
		end
	end

endmodule : bss_step

// File: verification/bss_pix_sink.sv
`timescale 1ns/10ps
// ************************************************
// Pixel sink, stalls one cycle in four
// ************************************************
module bss_pix_sink (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pixel stream
	input bss_pkg::bss_pix_t pix,
	input wire logic pix_valid,
	output logic pix_ready
);
	logic [1:0] phase_r;
	bss_pkg::bss_pix_t got_q[$];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

	assign pix_ready = (phase_r != 2'h3);

	// Record each accepted pixel
	always @(posedge pclk) begin
		if (presetn && pix_valid && pix_ready) begin
			got_q.push_back(pix);
		end
	end
endmodule : bss_pix_sink

// File: verification/tb_bss_top.sv
`timescale 1ns/10ps
module tb_bss_top;
	// ************************************************
	// Signals
	// ************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fb_wr_valid = 1'b0;
	logic [23:0] fb_wr_addr = 24'h000000;
	logic fb_wr_ready;
	bss_pkg::bss_pix_t pix;
	logic pix_valid;
	logic pix_ready;
	logic busy;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic er;
	logic [2:0] o;
	logic [15:0] vx;
	logic [15:0] vy;
	logic signed [15:0] r_err;
	logic [23:0] r_addr;
	logic [15:0] r_e1;
	logic [15:0] r_e2;
	logic [23:0] r_a1;
	logic [23:0] r_a2;
	localparam logic [23:0] W = 24'h000064;

	always #10 pclk = ~pclk;

	bss_top i_bss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fb_wr_valid(fb_wr_valid), .fb_wr_addr(fb_wr_addr),
		.fb_wr_ready(fb_wr_ready), .pix(pix), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.busy(busy));

	bss_pix_sink i_bss_pix_sink (.pclk(pclk), .presetn(presetn), .pix(pix),
		.pix_valid(pix_valid), .pix_ready(pix_ready));

	always @(posedge pclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	// ************************************************
	// Tasks
	// ************************************************
	task summarize;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1) @(negedge pclk);
		// Completing edge: take the answer here, then release
		@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic fb_wr(input logic [23:0] a);
		@(posedge pclk);
		fb_wr_valid <= 1'b1;
		fb_wr_addr <= a;
		@(negedge pclk);
		while (fb_wr_ready !== 1'b1) @(negedge pclk);
		@(posedge pclk);
		fb_wr_valid <= 1'b0;
	endtask : fb_wr

	task automatic setup_ref(input logic [2:0] oc, input logic [15:0] dx,
		input logic [15:0] dy, input logic env);
		logic [15:0] mj;
		logic [15:0] mn;
		logic [23:0] xs;
		logic [23:0] ys;
		mj = (dx > dy) ? dx : dy;
		mn = (dx > dy) ? dy : dx;
		xs = oc[0] ? 24'hFFFFFF : 24'h000001;
		ys = oc[1] ? -W : W;
		r_err = (mn << 1) - mj - {15'h0000, env};
		r_e1 = mn << 1;
		r_e2 = (mj - mn) << 1;
		r_a1 = oc[2] ? ys : xs;
		r_a2 = xs + ys;
	endtask : setup_ref

	// Compare drawn pixels against stepped reference
	task automatic seg(input int n, input logic is3d);
		repeat (3) @(negedge pclk);
		while (busy !== 1'b0 || pix_valid !== 1'b0) @(negedge pclk);
		chk(32'(i_bss_pix_sink.got_q.size()), 32'(n));
		for (int i = 0; i < n && i < i_bss_pix_sink.got_q.size(); i++) begin
			chk({8'h00, i_bss_pix_sink.got_q[i].addr}, {8'h00, r_addr});
			chk({31'h0, i_bss_pix_sink.got_q[i].is3d}, {31'h0, is3d});
			if (r_err < 0) begin
				r_err = r_err + r_e1;
				r_addr = r_addr + r_a1;
			end else begin
				r_err = r_err - r_e2;
				r_addr = r_addr + r_a2;
			end
		end
		i_bss_pix_sink.got_q.delete();
	endtask : seg

	// ************************************************
	// Tests
	// ************************************************
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			xfer(1'b0, 12'(k * 4), 32'h00000000);
			chk(rd, bss_pkg::RST_WORD);
		end
		$display("done: reset values");
		xfer(1'b1, bss_pkg::OFS_WIDTH, {8'h00, W});
		xfer(1'b1, bss_pkg::OFS_MODE, 32'h00000000);
		setup_ref(3'h0, 16'h0013, 16'h0002, 1'b0);
		xfer(1'b1, bss_pkg::OFS_SLOPE0, 32'h00020013);
		seg(0, 1'b0);
		xfer(1'b0, bss_pkg::OFS_SEGLEN, 32'h00000000);
		chk({28'h0, rd[3:0]}, 32'h00000003);
		xfer(1'b0, bss_pkg::OFS_ERR, 32'h00000000);
		chk({16'h0, rd[15:0]}, {16'h0, r_err});
		xfer(1'b1, bss_pkg::OFS_MODE, 32'h00002000);
		setup_ref(3'h0, 16'h0013, 16'h0002, 1'b1);
		xfer(1'b1, bss_pkg::OFS_SLOPE0, 32'h00020013);
		xfer(1'b0, bss_pkg::OFS_ERR, 32'h00000000);
		chk({16'h0, rd[15:0]}, {16'h0, r_err});
		$display("done: term setup");
		xfer(1'b1, bss_pkg::OFS_MODE, 32'h00000001);
		for (int k = 0; k < 8; k++) begin
			o = 3'(k);
			vx = o[2] ? 16'h0003 : 16'h0005;
			vy = o[2] ? 16'h0005 : 16'h0003;
			xfer(1'b1, bss_pkg::OFS_ADDR, 32'h00010000);
			seg(0, 1'b0);
			r_addr = 24'h010000;
			setup_ref(o, vx, vy, 1'b0);
			xfer(1'b1, 12'(k * 4), {vy, vx});
			seg(5, 1'b0);
			xfer(1'b0, 12'(k * 4), 32'h00000000);
			chk(rd, {vy, vx});
		end
		$display("done: octants");
		xfer(1'b1, bss_pkg::OFS_CONT, 32'h0000FFFF);
		xfer(1'b1, bss_pkg::OFS_CONT, 32'h0000FFFF);
		seg(32, 1'b0);
		xfer(1'b0, bss_pkg::OFS_ERR, 32'h00000000);
		chk({16'h0, rd[15:0]}, {16'h0, r_err});
		$display("done: continue");
		r_addr = 24'h020000;
		xfer(1'b1, bss_pkg::OFS_ADDR, 32'h00020000);
		setup_ref(3'h0, 16'h0013, 16'h0002, 1'b0);
		xfer(1'b1, bss_pkg::OFS_SLOPE0, 32'h00020013);
		seg(3, 1'b0);
		setup_ref(3'h0, 16'h0020, 16'h0000, 1'b0);
		xfer(1'b1, bss_pkg::OFS_SLOPE0, 32'h00000020);
		seg(16, 1'b0);
		xfer(1'b1, 12'h100, 32'h00000001);
		chk({31'h0, er}, 32'h00000001);
		seg(0, 1'b0);
		$display("done: lengths");
		r_addr = 24'h030000;
		fb_wr(24'h030000);
		seg(16, 1'b0);
		xfer(1'b1, bss_pkg::OFS_MODE, 32'h00000002);
		fb_wr(24'h040000);
		seg(0, 1'b0);
		xfer(1'b1, bss_pkg::OFS_ADDR, 32'h00050000);
		r_addr = 24'h050000;
		xfer(1'b1, bss_pkg::OFS_CONT, 32'h0000FFFF);
		xfer(1'b0, bss_pkg::OFS_SEGLEN, 32'h00000000);
		chk({31'h0, rd[bss_pkg::SEGLEN_BUSY_BIT]}, 32'h00000001);
		seg(16, 1'b1);
		$display("done: start paths");
		summarize();
	end
endmodule : tb_bss_top
